// File: hdl/pdv_pkg.sv
package pdv_pkg;

  // ****************************************
  // Register map, byte wide, printed offsets
  // ****************************************
  localparam logic [7:0]  ADDR_DIV_A_CFG = 8'hA4;  // Three bytes, low byte first
  localparam logic [7:0]  ADDR_DIV_B_CFG = 8'hA7;  // Three bytes, low byte first
  localparam logic [7:0]  ADDR_STATUS    = 8'hB0;  // Outputs and pending flags
  localparam logic [23:0] DIV_CFG_RST    = 24'h000000;
  localparam logic [2:0]  BYTES_ALL      = 3'h7;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          FLD_RATE_LSB   = 0;
  localparam int          FLD_SEL_LSB    = 16;
  localparam int          FLD_POL_BIT    = 18;
  localparam int          FLD_TYPE_BIT   = 19;
  localparam int          FLD_MODE_LSB   = 20;
  localparam logic [3:0]  MODE_SPECIAL   = 4'hF;
  localparam logic [1:0]  SEL_LF_A       = 2'h0;
  localparam logic [1:0]  SEL_LF_B       = 2'h1;

  // Bit layout matches the 24-bit register image
  typedef struct packed {
    logic [3:0]  mode;
    logic        edge_bnd;
    logic        neg_pol;
    logic [1:0]  sel;
    logic [15:0] rate;
  } pdv_cfg_t;

  typedef enum logic [1:0] {
    PDV_REG,
    PDV_LF,
    PDV_FRM
  } pdv_mode_t;

endpackage

// File: hdl/pdv_top.sv
// Notes on behaviour
// - A with mode 1111 and selector 00 gives base frequency over bits 15:0, 50% duty.
// - A with mode 1111, selector not 00, gives frame pulse one selected period wide.
// - Mode not 1111 gives 50% duty output clock divided by full 24 bits.
// - B with mode 1111 and selector 01 gives base frequency over bits 15:0.
// - B with mode 1111, selector not 01, gives frame pulse one period wide.
// - Frame pulses are spaced by bits 15:0 periods of the selected clock.
// - B selector: 00 A, 01 low frequency, 10 C, 11 D.
// - Bit 18 zero gives positive frame pulse, one gives negative.
// - Bit 19 zero centres boundary in pulse, one puts it at first edge.
// - Mode not 1111 makes bits 19:0 plain divider bits.
// - Mode field picks frame pulse, low frequency clock or regular clock.
// - A selector: 00 low frequency, 01 B, 10 C, 11 D.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// One post-divider output channel
// ****************************************
module pdv_channel #(
  parameter logic [1:0] LF_SEL = 2'h0
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire pdv_pkg::pdv_cfg_t cfg_i,
  input  wire logic             out_tick_i,
  input  wire logic             base_tick_i,
  input  wire logic [3:0]       src_vec_i,
  output logic                  out_o
);

  logic [23:0]       div_cnt_r;
  logic [23:0]       div_cnt_nxt;
  logic              clk_r;
  logic              clk_nxt;
  logic              src_q_r;
  logic [15:0]       frm_cnt_r;
  logic [15:0]       frm_cnt_nxt;
  logic              frm_r;
  logic              frm_nxt;
  logic              out_r;
  logic              out_nxt;
  pdv_pkg::pdv_mode_t mode_c;
  logic [23:0]       divisor_c;
  logic              tick_c;
  logic              wrap_c;
  logic              src_c;
  logic              rise_c;
  logic              fall_c;
  logic              last_c;

  always_comb begin
    if (cfg_i.mode != pdv_pkg::MODE_SPECIAL) begin
      mode_c = pdv_pkg::PDV_REG;
    end else if (cfg_i.sel == LF_SEL) begin
      mode_c = pdv_pkg::PDV_LF;
    end else begin
      mode_c = pdv_pkg::PDV_FRM;
    end
    // Whole image is the ratio outside the special mode
    divisor_c = (mode_c == pdv_pkg::PDV_REG) ? 24'(cfg_i) : {8'h00, cfg_i.rate};
    tick_c    = (mode_c == pdv_pkg::PDV_REG) ? out_tick_i : base_tick_i;
    wrap_c    = ({1'b0, div_cnt_r} + 25'h0000001) >= {1'b0, divisor_c};
    div_cnt_nxt = div_cnt_r;
    if (tick_c) begin
      div_cnt_nxt = wrap_c ? 24'h000000 : div_cnt_r + 24'h000001;
    end
    // High for the first half of each ratio; ratios below 2 hold low
    clk_nxt = div_cnt_nxt < (divisor_c >> 1);
    src_c   = src_vec_i[cfg_i.sel];
    rise_c  = src_c & ~src_q_r;
    fall_c  = ~src_c & src_q_r;
    last_c  = ({1'b0, frm_cnt_r} + 17'h00001) >= {1'b0, cfg_i.rate};
    frm_cnt_nxt = frm_cnt_r;
    if (rise_c) begin
      frm_cnt_nxt = last_c ? 16'h0000 : frm_cnt_r + 16'h0001;
    end
    frm_nxt = frm_r;
    // Boundary is the rising edge on which the spacing counter wraps
    if (cfg_i.edge_bnd) begin
      if (rise_c) begin
        frm_nxt = last_c;
      end
    end else if (fall_c) begin
      frm_nxt = last_c;
    end
    if (mode_c == pdv_pkg::PDV_FRM) begin
      out_nxt = frm_nxt ^ cfg_i.neg_pol;
    end else begin
      out_nxt = clk_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_r <= 24'h000000;
      clk_r     <= 1'b0;
      src_q_r   <= 1'b0;
      frm_cnt_r <= 16'h0000;
      frm_r     <= 1'b0;
      out_r     <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      clk_r     <= clk_nxt;
      src_q_r   <= src_c;
      frm_cnt_r <= frm_cnt_nxt;
      frm_r     <= frm_nxt;
      out_r     <= out_nxt;
    end
  end

  assign out_o = out_r;

  // ****************************************
  // Checks
  // ****************************************
  a_reg_tick_only: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (mode_c == pdv_pkg::PDV_REG && !out_tick_i) |=> (clk_r == $past(clk_r)))
    else $error("Regular clock moved without an output tick");

  a_lf_base_tick: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (mode_c == pdv_pkg::PDV_LF && !base_tick_i) |=> $stable(div_cnt_r))
    else $error("Low frequency divider moved without a base tick");

  a_div_wrap_zero: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (tick_c && wrap_c) |=> (div_cnt_r == 24'h000000))
    else $error("Divider did not wrap at its ratio");

  a_frm_spacing: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (rise_c && last_c) |=> (frm_cnt_r == 16'h0000 && (!$past(cfg_i.edge_bnd) || frm_r)))
    else $error("Frame boundary not taken at spacing count");

  a_frm_edge_hold: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (cfg_i.edge_bnd && !rise_c) |=> $stable(frm_r))
    else $error("First-edge frame pulse moved off a rising edge");

  a_frm_polarity: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (mode_c == pdv_pkg::PDV_FRM) |=> (cfg_i != $past(cfg_i)) || (out_o == (frm_r ^ cfg_i.neg_pol)))
    else $error("Frame pulse polarity wrong");

endmodule // pdv_channel

// ****************************************
// Register file and the two channels
// ****************************************
module pdv_top (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_stb_i,
  input  wire logic       rd_stb_i,
  output logic      [7:0] rdata_o,
  input  wire logic       synth_out_tick_i,
  input  wire logic       synth_base_tick_i,
  input  wire logic       div_c_clk_i,
  input  wire logic       div_d_clk_i,
  output logic            div_a_out_o,
  output logic            div_b_out_o
);

  pdv_pkg::pdv_cfg_t cfg_a_r;
  pdv_pkg::pdv_cfg_t cfg_a_nxt;
  pdv_pkg::pdv_cfg_t cfg_b_r;
  pdv_pkg::pdv_cfg_t cfg_b_nxt;
  logic [23:0]       shd_a_r;
  logic [23:0]       shd_a_nxt;
  logic [23:0]       shd_b_r;
  logic [23:0]       shd_b_nxt;
  logic [2:0]        msk_a_r;
  logic [2:0]        msk_a_nxt;
  logic [2:0]        msk_b_r;
  logic [2:0]        msk_b_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic [7:0]        off_a_c;
  logic [7:0]        off_b_c;
  logic              hit_a_c;
  logic              hit_b_c;
  logic              commit_a_c;
  logic              commit_b_c;
  logic [3:0]        src_a_c;
  logic [3:0]        src_b_c;

  always_comb begin
    off_a_c   = addr_i - pdv_pkg::ADDR_DIV_A_CFG;
    off_b_c   = addr_i - pdv_pkg::ADDR_DIV_B_CFG;
    hit_a_c   = off_a_c < 8'h03;
    hit_b_c   = off_b_c < 8'h03;
    shd_a_nxt = shd_a_r;
    shd_b_nxt = shd_b_r;
    msk_a_nxt = msk_a_r;
    msk_b_nxt = msk_b_r;
    cfg_a_nxt = cfg_a_r;
    cfg_b_nxt = cfg_b_r;
    commit_a_c = 1'b0;
    commit_b_c = 1'b0;
    if (wr_stb_i && hit_a_c) begin
      shd_a_nxt[off_a_c[1:0]*8 +: 8] = wdata_i;
      msk_a_nxt[off_a_c[1:0]]        = 1'b1;
    end
    if (wr_stb_i && hit_b_c) begin
      shd_b_nxt[off_b_c[1:0]*8 +: 8] = wdata_i;
      msk_b_nxt[off_b_c[1:0]]        = 1'b1;
    end
    // Partial writes never reach the dividers
    if (msk_a_nxt == pdv_pkg::BYTES_ALL) begin
      commit_a_c = 1'b1;
      cfg_a_nxt  = shd_a_nxt;
      msk_a_nxt  = 3'h0;
    end
    if (msk_b_nxt == pdv_pkg::BYTES_ALL) begin
      commit_b_c = 1'b1;
      cfg_b_nxt  = shd_b_nxt;
      msk_b_nxt  = 3'h0;
    end
    rdata_nxt = 8'h00;
    if (rd_stb_i) begin
      if (hit_a_c) begin
        rdata_nxt = 8'(24'(cfg_a_r) >> (off_a_c[1:0]*8));
      end else if (hit_b_c) begin
        rdata_nxt = 8'(24'(cfg_b_r) >> (off_b_c[1:0]*8));
      end else if (addr_i == pdv_pkg::ADDR_STATUS) begin
        rdata_nxt = {2'h0, msk_b_r, msk_a_r[1:0] != 2'h0 || msk_a_r[2], div_b_out_o, div_a_out_o};
      end
    end
    // Selector index order, left to right: 11, 10, 01, 00
    src_a_c = {div_d_clk_i, div_c_clk_i, div_b_out_o, 1'b0};
    src_b_c = {div_d_clk_i, div_c_clk_i, 1'b0, div_a_out_o};
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_a_r <= pdv_pkg::DIV_CFG_RST;
      cfg_b_r <= pdv_pkg::DIV_CFG_RST;
      shd_a_r <= pdv_pkg::DIV_CFG_RST;
      shd_b_r <= pdv_pkg::DIV_CFG_RST;
      msk_a_r <= 3'h0;
      msk_b_r <= 3'h0;
      rdata_r <= 8'h00;
    end else begin
      cfg_a_r <= cfg_a_nxt;
      cfg_b_r <= cfg_b_nxt;
      shd_a_r <= shd_a_nxt;
      shd_b_r <= shd_b_nxt;
      msk_a_r <= msk_a_nxt;
      msk_b_r <= msk_b_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // Channel A: low frequency on selector 00
  pdv_channel #(.LF_SEL(pdv_pkg::SEL_LF_A)) u_div_a (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .cfg_i       (cfg_a_r),
    .out_tick_i  (synth_out_tick_i),
    .base_tick_i (synth_base_tick_i),
    .src_vec_i   (src_a_c),
    .out_o       (div_a_out_o)
  );

  // Channel B: low frequency on selector 01
  pdv_channel #(.LF_SEL(pdv_pkg::SEL_LF_B)) u_div_b (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .cfg_i       (cfg_b_r),
    .out_tick_i  (synth_out_tick_i),
    .base_tick_i (synth_base_tick_i),
    .src_vec_i   (src_b_c),
    .out_o       (div_b_out_o)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_commit_all_bytes: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (cfg_a_r != $past(cfg_a_r)) |-> $past(commit_a_c))
    else $error("Divider A setting changed before all bytes written");

  a_rd_one_cycle: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !$past(rd_stb_i) |-> (rdata_o == 8'h00))
    else $error("Read data outside its single cycle");

  a_b_src_map: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (cfg_b_r.sel == 2'h0) |-> (src_b_c[cfg_b_r.sel] == div_a_out_o))
    else $error("Divider B selector 00 not tied to divider A");

endmodule // pdv_top

`default_nettype wire

// File: verif/test_synth_post_divider_frame_gen.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(NM, EXP, GOT) begin checked++; if ((GOT) !== (EXP)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", NM, EXP, GOT); end end

module test_synth_post_divider_frame_gen;
  logic       core_clk_i = 1'b0;
  logic       arst_n_i   = 1'b0;
  logic [7:0] addr_i     = 8'h00;
  logic [7:0] wdata_i    = 8'h00;
  logic       wr_stb_i   = 1'b0;
  logic       rd_stb_i   = 1'b0;
  logic       out_tick   = 1'b0;
  logic       base_tick  = 1'b0;
  logic       c_clk      = 1'b0;
  logic       d_clk      = 1'b0;
  logic [7:0] rdata_o;
  logic       a_out;
  logic       b_out;
  logic [7:0] rd_v;
  int         bad_count  = 0;
  int         checked    = 0;
  int         cyc        = 0;
  int         hi;
  int         r;
  logic       c_hist[$];

  always #20 core_clk_i = ~core_clk_i;

  pdv_top dut_u (
    .core_clk_i       (core_clk_i),
    .arst_n_i         (arst_n_i),
    .addr_i           (addr_i),
    .wdata_i          (wdata_i),
    .wr_stb_i         (wr_stb_i),
    .rd_stb_i         (rd_stb_i),
    .rdata_o          (rdata_o),
    .synth_out_tick_i (out_tick),
    .synth_base_tick_i(base_tick),
    .div_c_clk_i      (c_clk),
    .div_d_clk_i      (d_clk),
    .div_a_out_o      (a_out),
    .div_b_out_o      (b_out)
  );

  // ****************************************
  // Related clocks and the model's history
  // ****************************************
  // C period 8 cycles, D period 12, so each source gives a distinct width
  always @(posedge core_clk_i) begin
    cyc   <= cyc + 1;
    c_clk <= 1'((cyc / 4) % 2);
    d_clk <= 1'((cyc / 6) % 2);
  end

  always @(negedge core_clk_i) begin
    c_hist.push_front(c_clk);
    if (c_hist.size() > 4) begin
      c_hist.pop_back();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i   <= a;
    wdata_i  <= d;
    wr_stb_i <= 1'b1;
    @(posedge core_clk_i);
    wr_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_i   <= a;
    rd_stb_i <= 1'b1;
    @(posedge core_clk_i);
    rd_stb_i <= 1'b0;
    @(negedge core_clk_i);
    d = rdata_o;
  endtask

  task automatic cfg(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) wr(a + 8'(i), v[8*i +: 8]);
  endtask

  task automatic chk_cfg(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      rd(a + 8'(i), rd_v);
      `CHK("cfg byte", v[8*i +: 8], rd_v)
    end
  endtask

  // Counting highs over whole periods makes the result phase-free
  task automatic measure(input logic use_b, input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge core_clk_i);
      if ((use_b ? b_out : a_out) === 1'b1) h++;
    end
  endtask

  task automatic div_chk(input logic use_b, input logic [23:0] v, input int n);
    cfg(use_b ? pdv_pkg::ADDR_DIV_B_CFG : pdv_pkg::ADDR_DIV_A_CFG, v);
    repeat (128) @(posedge core_clk_i);
    measure(use_b, n, hi);
    `CHK("duty", n / 2, hi)
  endtask

  task automatic frame(input logic use_b, input logic [23:0] v, input int per);
    int n;
    int e;
    n = 4 * int'(v[15:0]) * per;
    e = v[18] ? n - 4 * per : 4 * per;
    cfg(use_b ? pdv_pkg::ADDR_DIV_B_CFG : pdv_pkg::ADDR_DIV_A_CFG, v);
    repeat (100) @(posedge core_clk_i);
    measure(use_b, n, hi);
    `CHK("frame high", e, hi)
  endtask

  task automatic phase(input logic [23:0] v);
    logic prev;
    logic now;
    logic found;
    prev  = 1'b1;
    found = 1'b0;
    cfg(pdv_pkg::ADDR_DIV_A_CFG, v);
    repeat (100) @(posedge core_clk_i);
    for (int i = 0; i < 200 && !found; i++) begin
      @(negedge core_clk_i);
      #1;
      now   = a_out ^ v[18];
      found = now && !prev;
      prev  = now;
    end
    // Output flop lags the selected edge by one cycle
    `CHK("boundary", v[19] ? 3'b110 : 3'b101, {found, c_hist[1], c_hist[2]})
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    void'($urandom(71078));
    repeat (3) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    chk_cfg(pdv_pkg::ADDR_DIV_A_CFG, 24'h000000);
    chk_cfg(pdv_pkg::ADDR_DIV_B_CFG, 24'h000000);
    wr(8'hC1, 8'h5A);
    rd(8'hC1, rd_v);
    `CHK("unmapped", 8'h00, rd_v)
    measure(1'b0, 40, hi);
    `CHK("ratio zero", 0, hi)
    @(posedge core_clk_i);
    out_tick <= 1'b1;
    cfg(pdv_pkg::ADDR_DIV_A_CFG, 24'h000010);
    wr(8'hA4, 8'h22);
    wr(8'hA5, 8'h00);
    rd(pdv_pkg::ADDR_STATUS, rd_v);
    `CHK("status pending", 4'h1, rd_v[5:2])
    chk_cfg(pdv_pkg::ADDR_DIV_A_CFG, 24'h000010);
    wr(8'hA6, 8'h00);
    chk_cfg(pdv_pkg::ADDR_DIV_A_CFG, 24'h000022);
    for (int k = 0; k < 3; k++) begin
      r = 2 + int'($urandom % 30);
      div_chk(1'b0, 24'(r), r);
      div_chk(1'b1, 24'(r + 1), r + 1);
    end
    // Regular tick stopped: only the base tick may move these
    @(posedge core_clk_i);
    out_tick  <= 1'b0;
    base_tick <= 1'b1;
    div_chk(1'b0, 24'hF00000 | 24'(r), r);
    div_chk(1'b1, 24'hF10000 | 24'(r), r);
    @(posedge core_clk_i);
    base_tick <= 1'b0;
    out_tick  <= 1'b1;
    div_chk(1'b0, 24'h000004, 4);
    frame(1'b1, 24'hF80003, 4);
    frame(1'b1, 24'hFC0003, 4);
    frame(1'b1, 24'hFA0003, 8);
    frame(1'b1, 24'hF30002, 12);
    div_chk(1'b1, 24'h000006, 6);
    frame(1'b0, 24'hF90002, 6);
    frame(1'b0, 24'hFA0003, 8);
    frame(1'b0, 24'hFF0002, 12);
    phase(24'hFA0003);
    phase(24'hF20003);
    div_chk(1'b1, 24'h010002, 65538);
    end_sim();
  end

  initial begin
    repeat (90000) @(posedge core_clk_i);
    bad_count++;
    end_sim();
  end
endmodule // test_synth_post_divider_frame_gen
`undef CHK
`default_nettype wire
